// ### anp_next_page_regs.sv
// What this block does
// R1: transmit page bit 15 set means more next pages follow; clear marks the last.
// R2: transmit page bit 13 set marks a message page, clear an unformatted page.
// R3: transmit page bit 12 set means able to comply with the message.
// R4: toggle bit inverts relative to the previously exchanged link code word.
// R5: first next page toggle is the complement of base page bit 11.
// R6: bits 10 to 0 carry the 11-bit code field, reset to zero.
// R7: transmit register is read only; resets to more pages one, others zero.
// R8: received partner page held in its own read only register; bit 15 resets one.
// R9: received acknowledge bit set only after three consecutive consistent bursts.
`timescale 1ns/1ps
module anp_next_page_regs #(
  parameter int MATCH_BURSTS = anp_pkg::ANP_MATCH_BURSTS
) (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  // host register read port
  input  wire logic [7:0]  host_addr,
  input  wire logic        host_rd,
  output logic [15:0]      host_rdata,
  output logic             host_rvalid,
  // auto-negotiation engine, transmit side
  input  wire logic        an_restart,
  input  wire logic        np_load,
  input  wire logic        np_more_pages,
  input  wire logic        np_message_page,
  input  wire logic        np_comply_ack,
  input  wire logic [10:0] np_code,
  input  wire logic        base_page_done,
  input  wire logic        base_toggle,
  input  wire logic        np_exchanged,
  output logic [15:0]      tx_page_word,
  // auto-negotiation engine, receive side
  input  wire logic        burst_valid,
  input  wire logic [15:0] burst_word,
  output logic             rx_page_update
);

  // ==========================================================
  // transmit next page fields
  logic                             more_pages_flag;
  logic                             message_page_flag;
  logic                             comply_acknowledge;
  logic                             toggle;
  logic [anp_pkg::ANP_CODE_WIDTH-1:0] code_field;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      more_pages_flag    <= anp_pkg::ANP_TX_NP_RESET[anp_pkg::ANP_MORE_PAGES_BIT]; // [R7]
      message_page_flag  <= anp_pkg::ANP_TX_NP_RESET[anp_pkg::ANP_MSG_PAGE_BIT];
      comply_acknowledge <= anp_pkg::ANP_TX_NP_RESET[anp_pkg::ANP_COMPLY_BIT];
      code_field         <= anp_pkg::ANP_TX_NP_RESET[anp_pkg::ANP_CODE_MSB:0]; // [R6]
    end else if (np_load) begin
      more_pages_flag    <= np_more_pages;   // [R1]
      message_page_flag  <= np_message_page; // [R2]
      comply_acknowledge <= np_comply_ack;   // [R3]
      code_field         <= np_code;         // [R6]
    end
  end

  // base page wins over an exchange in the same cycle: it starts a new sequence
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      toggle <= anp_pkg::ANP_TX_NP_RESET[anp_pkg::ANP_TOGGLE_BIT];
    end else if (base_page_done) begin
      toggle <= ~base_toggle; // [R5]
    end else if (np_exchanged) begin
      toggle <= ~toggle; // [R4]
    end
  end

  // reserved bit 14 is always zero in the transmitted word
  wire [15:0] tx_word = {more_pages_flag, 1'b0, message_page_flag,
                         comply_acknowledge, toggle, code_field}; // [R7]

  assign tx_page_word = tx_word;

  // ==========================================================
  // received partner next page
  logic        match_pulse;
  logic [15:0] match_word;
  logic [15:0] rx_page;

  anp_burst_match #(
    .MATCH_BURSTS (MATCH_BURSTS)
  ) u_match (
    .sys_clk     (sys_clk),
    .sys_rst     (sys_rst),
    .restart     (an_restart),
    .burst_valid (burst_valid),
    .burst_word  (burst_word),
    .match_pulse (match_pulse),
    .match_word  (match_word)
  );

  // ack only shows once the burst run has agreed; a restart drops it
  // the update strobe rises with the new word, so a read it triggers never sees stale data
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_page        <= anp_pkg::ANP_RX_NP_RESET; // [R8]
      rx_page_update <= 1'b0;
    end else if (an_restart) begin
      rx_page[anp_pkg::ANP_ACK_BIT] <= 1'b0;
      rx_page_update                <= 1'b0;
    end else begin
      rx_page_update <= match_pulse;
      if (match_pulse) begin
        rx_page                       <= match_word; // [R8]
        rx_page[anp_pkg::ANP_ACK_BIT] <= 1'b1;       // [R9]
      end
    end
  end

  // ==========================================================
  // host read decode; writes do not exist, both registers read only
  wire hit_tx = (host_addr == anp_pkg::ANP_TX_NP_OFFSET);
  wire hit_rx = (host_addr == anp_pkg::ANP_RX_NP_OFFSET);
  wire [15:0] next_host_rdata = hit_tx ? tx_word :
                                hit_rx ? rx_page : 16'h0000; // [R7]

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      host_rdata  <= 16'h0000;
      host_rvalid <= 1'b0;
    end else begin
      host_rvalid <= host_rd;
      if (host_rd) begin
        host_rdata <= next_host_rdata;
      end
    end
  end

endmodule : anp_next_page_regs

// ### anp_pkg.sv
package anp_pkg;

  // ==========================================================
  // register map
  localparam logic [7:0]  ANP_TX_NP_OFFSET   = 8'hdc;
  localparam logic [7:0]  ANP_RX_NP_OFFSET   = 8'hde;

  // ==========================================================
  // next page field layout
  localparam int          ANP_MORE_PAGES_BIT = 15;
  localparam int          ANP_ACK_BIT        = 14;
  localparam int          ANP_MSG_PAGE_BIT   = 13;
  localparam int          ANP_COMPLY_BIT     = 12;
  localparam int          ANP_TOGGLE_BIT     = 11;
  localparam int          ANP_CODE_MSB       = 10;
  localparam int          ANP_CODE_WIDTH     = 11;

  // ==========================================================
  // reset values
  localparam logic [15:0] ANP_TX_NP_RESET    = 16'h8000;
  localparam logic [15:0] ANP_RX_NP_RESET    = 16'h8000;

  // ==========================================================
  // consistency count before acknowledge
  localparam int          ANP_MATCH_BURSTS   = 3;

endpackage : anp_pkg

// ### anp_burst_match.sv
`timescale 1ns/1ps
// ==========================================================
// counts consecutive bursts whose words agree, ack bit ignored
module anp_burst_match #(
  parameter int MATCH_BURSTS = anp_pkg::ANP_MATCH_BURSTS
) (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        restart,
  input  wire logic        burst_valid,
  input  wire logic [15:0] burst_word,
  output logic             match_pulse,
  output logic [15:0]      match_word
);

  localparam int CW = $clog2(MATCH_BURSTS + 1);

  logic [15:0] last_word;
  logic [CW-1:0] run_count;
  logic          have_last;

  wire  [15:0] ack_mask   = ~(16'h0001 << anp_pkg::ANP_ACK_BIT);
  wire         same_word  = have_last && ((burst_word & ack_mask) == (last_word & ack_mask));
  wire [CW-1:0] next_run_count = same_word ? run_count + CW'(1) : CW'(1);
  // a long agreeing run saturates so it cannot wrap back below the limit
  wire         at_limit   = (run_count == CW'(MATCH_BURSTS));
  wire         reach      = burst_valid && (next_run_count == CW'(MATCH_BURSTS))
                            && !(same_word && at_limit);

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      last_word   <= 16'h0000;
      run_count   <= '0;
      have_last   <= 1'b0;
      match_pulse <= 1'b0;
      match_word  <= 16'h0000;
    end else if (restart) begin
      have_last   <= 1'b0;
      run_count   <= '0;
      match_pulse <= 1'b0;
    end else begin
      match_pulse <= reach; // [R9]
      if (burst_valid) begin
        last_word <= burst_word;
        have_last <= 1'b1;
        if (!(same_word && at_limit)) begin
          run_count <= next_run_count;
        end
      end
      if (reach) begin
        match_word <= burst_word;
      end
    end
  end

endmodule : anp_burst_match

// ### anp_next_page_regs_props.sv
`timescale 1ns/1ps
// ==========================================================
// port checks
module anp_next_page_regs_props #(
  parameter int MATCH_BURSTS = anp_pkg::ANP_MATCH_BURSTS
) (
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  input wire logic [7:0]  host_addr,
  input wire logic        host_rd,
  input wire logic [15:0] host_rdata,
  input wire logic        host_rvalid,
  input wire logic        an_restart,
  input wire logic        np_load,
  input wire logic        np_more_pages,
  input wire logic        np_message_page,
  input wire logic        np_comply_ack,
  input wire logic [10:0] np_code,
  input wire logic        base_page_done,
  input wire logic        base_toggle,
  input wire logic        np_exchanged,
  input wire logic [15:0] tx_page_word,
  input wire logic        burst_valid,
  input wire logic        rx_page_update
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  a_rvalid_after_rd: assert property (host_rd |=> host_rvalid)
    else $error("read unanswered");
  a_tx_read_data: assert property (host_rd && host_addr == 8'hdc
    |=> host_rdata == $past(tx_page_word)) else $error("bad tx read");
  a_load_more_pages: assert property (np_load |=> tx_page_word[15] == $past(np_more_pages))
    else $error("bad more pages");
  a_load_class_bits: assert property (np_load |=> tx_page_word[13] == $past(np_message_page)
    && tx_page_word[12] == $past(np_comply_ack)) else $error("bad class bits");
  a_load_code_field: assert property (np_load |=> tx_page_word[10:0] == $past(np_code))
    else $error("bad code");
  a_toggle_inverts: assert property (np_exchanged && !base_page_done
    |=> tx_page_word[11] != $past(tx_page_word[11])) else $error("no toggle");
  a_first_toggle: assert property (base_page_done |=> tx_page_word[11] == !$past(base_toggle))
    else $error("bad first toggle");
  a_update_after_burst: assert property (rx_page_update |-> $past(burst_valid, 2))
    else $error("stray update");
  a_reserved_zero: assert property (tx_page_word[14] == 1'b0)
    else $error("reserved bit set");
  a_unmapped_read_zero: assert property (host_rd && host_addr != 8'hdc && host_addr != 8'hde
    |=> host_rdata == 16'h0000) else $error("unmapped read not zero");
endmodule : anp_next_page_regs_props

bind anp_next_page_regs anp_next_page_regs_props #(.MATCH_BURSTS(MATCH_BURSTS)) u_props (.*);

// ### anp_link_partner.sv
`timescale 1ns/1ps
// ==========================================================
// remote partner: one word per burst; the word lines are inverted between bursts
module anp_link_partner (
  input  wire logic   sys_clk,
  output logic        burst_valid,
  output logic [15:0] burst_word
);
  initial begin
    burst_valid = 1'b0;
    burst_word  = 16'h0000;
  end
  task automatic send(input logic [15:0] word);
    burst_valid <= 1'b1;
    burst_word  <= word;
    @(posedge sys_clk);
    burst_valid <= 1'b0;
    burst_word  <= ~word; // stale word inverted so a missed valid shows up
    @(posedge sys_clk);
  endtask : send
endmodule : anp_link_partner

// ### anp_next_page_regs_test.sv
`timescale 1ns/1ps
module anp_next_page_regs_test;
  logic        sys_clk = 1'b0, sys_rst = 1'b1, host_rd = 1'b0, an_restart = 1'b0;
  logic        np_load = 1'b0, np_more_pages = 1'b0, np_message_page = 1'b0;
  logic        np_comply_ack = 1'b0, base_page_done = 1'b0, base_toggle = 1'b0;
  logic        np_exchanged = 1'b0, host_rvalid, rx_page_update, burst_valid, seen = 1'b0;
  logic [7:0]  host_addr = 8'h00;
  logic [10:0] np_code = 11'h000;
  logic [15:0] host_rdata, tx_page_word, burst_word;
  int          errors = 0, checks = 0, cycles = 0;
  anp_next_page_regs u_dut (
    .sys_clk         (sys_clk),
    .sys_rst         (sys_rst),
    .host_addr       (host_addr),
    .host_rd         (host_rd),
    .host_rdata      (host_rdata),
    .host_rvalid     (host_rvalid),
    .an_restart      (an_restart),
    .np_load         (np_load),
    .np_more_pages   (np_more_pages),
    .np_message_page (np_message_page),
    .np_comply_ack   (np_comply_ack),
    .np_code         (np_code),
    .base_page_done  (base_page_done),
    .base_toggle     (base_toggle),
    .np_exchanged    (np_exchanged),
    .tx_page_word    (tx_page_word),
    .burst_valid     (burst_valid),
    .burst_word      (burst_word),
    .rx_page_update  (rx_page_update)
  );
  anp_link_partner u_partner (.sys_clk(sys_clk), .burst_valid(burst_valid), .burst_word(burst_word));
  initial forever #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (rx_page_update === 1'b1) seen <= 1'b1;
    if (cycles == 2000) begin
      errors = errors + 1;
      complete_run();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic rd(input logic [7:0] addr, input logic [15:0] exp);
    host_addr <= addr;
    host_rd   <= 1'b1;
    @(posedge sys_clk) host_rd <= 1'b0;
    #1 chk({15'h0000, host_rvalid}, 16'h0001);
    chk(host_rdata, exp);
    @(posedge sys_clk);
  endtask : rd
  // kind: base done, load, exchanged, restart; val: base toggle, more, msg, comply, code
  task automatic ev(input logic [3:0] kind, input logic [14:0] val, input logic [15:0] exp);
    {base_page_done, np_load, np_exchanged, an_restart} <= kind;
    {base_toggle, np_more_pages, np_message_page, np_comply_ack, np_code} <= val;
    @(posedge sys_clk) {base_page_done, np_load, np_exchanged, an_restart} <= 4'h0;
    #1 chk(tx_page_word, exp);
    @(posedge sys_clk);
  endtask : ev
  task automatic complete_run();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run
  initial begin
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    chk(tx_page_word, 16'h8000);
    rd(8'hdc, 16'h8000);
    rd(8'hde, 16'h8000);
    rd(8'h40, 16'h0000);
    ev(4'h8, 15'h0000, 16'h8800);
    ev(4'h4, 15'h1fff, 16'h3fff);
    ev(4'h2, 15'h0000, 16'h37ff);
    ev(4'h2, 15'h0000, 16'h3fff);
    ev(4'h8, 15'h4000, 16'h37ff);
    ev(4'h4, 15'h22aa, 16'h82aa);
    rd(8'hdc, 16'h82aa);
    u_partner.send(16'h1234);
    u_partner.send(16'h1235);
    u_partner.send(16'h5235);
    rd(8'hde, 16'h8000);
    chk({15'h0000, seen}, 16'h0000);
    u_partner.send(16'h1235);
    rd(8'hde, 16'h5235);
    chk({15'h0000, seen}, 16'h0001);
    ev(4'h1, 15'h0000, 16'h82aa);
    rd(8'hde, 16'h1235);
    // second reset in mid-run must bring both registers back
    sys_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    rd(8'hdc, 16'h8000);
    rd(8'hde, 16'h8000);
    complete_run();
  end
endmodule : anp_next_page_regs_test
